// *** bench/smd_ctrl_model.sv ***
// Purpose: controller side that drives step and direction
// Assumes: drive inputs change at the falling clock edge
// Notes:   pulse stays high three cycles, spacing set by the caller
`timescale 1ns/10ps
module smd_ctrl_model (
  input  wire logic clk,
  input  wire logic ready,
  input  wire logic seek_complete,
  output logic      step,
  output logic      direction_in
);
  // ==========================================================
  // idle levels
  initial begin
    step = 1'b0;
    direction_in = 1'b0;
  end
  // ==========================================================
  // n pulses gap cycles apart, gap under 3500 cycles
  task automatic seek(input int n, input logic dir, input int gap);
    int t;
    t = 0;
    // first pulse once ready and on track, or after 4000 cycles of waiting
    while (!(ready === 1'b1 && seek_complete === 1'b1) &&
           t < 4000) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    direction_in = dir;
    repeat (n) begin
      step = 1'b1;
      repeat (3) @(negedge clk);
      step = 1'b0;
      repeat (gap - 3) @(negedge clk);
    end
    // direction is left as it is until the next seek
  endtask
endmodule

// *** bench/smd_drive_tb.sv ***
// Purpose: self-checking bench of the step-mode drive logic
// Assumes: short settle, revolution and move counts
// Notes:   partner model makes the step pulses
`timescale 1ns/10ps
module smd_drive_tb;
  import smd_pkg::*;
  // ==========================================================
  // signals
  logic       clk, rst, write_gate, read_gate, write_data;
  logic       write_current, spin_ok, step, direction_in;
  logic [1:0] unit_sel;
  logic [3:0] head_sel;
  logic       drive_selected, ready, seek_complete, track0;
  logic       write_fault, index_pulse, ref_clk, write_enable;
  logic       write_bit, gap_window, prot_oe_n, prot_o, chg_oe_n, chg_o;
  int         mismatches, n_compared;
  // ==========================================================
  // instances, short counts keep the run brief
  smd_drive #(.UNIT_ADDR(1), .SETTLE_LEN(50), .REV_LEN(5000),
    .MOVE_LEN(10)) smd_drive_inst (.clk(clk), .rst(rst),
    .unit_sel(unit_sel), .head_sel(head_sel), .write_gate(write_gate),
    .read_gate(read_gate), .direction_in(direction_in), .step(step),
    .write_data(write_data), .write_current(write_current),
    .spin_ok(spin_ok), .drive_selected(drive_selected), .ready(ready),
    .seek_complete(seek_complete), .track0(track0),
    .write_fault(write_fault), .index_pulse(index_pulse),
    .ref_clk(ref_clk), .write_enable(write_enable),
    .write_bit(write_bit), .gap_window(gap_window),
    .prot_oe_n(prot_oe_n), .prot_o(prot_o), .chg_oe_n(chg_oe_n),
    .chg_o(chg_o));
  smd_ctrl_model smd_ctrl_model_inst (.clk(clk), .ready(ready),
    .seek_complete(seek_complete), .step(step),
    .direction_in(direction_in));
  // ==========================================================
  // clock, and write data that toggles while the gate is up
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) write_data <= write_gate & ~write_data;
  // ==========================================================
  // compare, verdict, watchdog
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    stop_test;
  end
  // bounded wait for seek complete
  task automatic wait_sc;
    int n;
    n = 0;
    while (seek_complete !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(seek_complete, 1'b1);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk({seek_complete, track0, write_fault, ready}, 4'hd);
    chk({prot_oe_n, chg_oe_n, prot_o, chg_o}, 4'hc);
  endtask
  // drop timing, travel inward at the shortest spacing
  task automatic t_drop;
    int n;
    fork
      smd_ctrl_model_inst.seek(3, 1'b1, STEP_MIN_CYC);
      begin
        @(posedge step);
        n = 0;
        while (seek_complete !== 1'b0 && n < 100) begin
          @(negedge clk);
          n++;
        end
        chk(n <= SC_DROP_CYC, 1'b1);
      end
    join
    wait_sc;
    chk(track0, 1'b0);
  endtask
  // fast reverse burst past track zero, then one more outward
  task automatic t_over;
    smd_ctrl_model_inst.seek(8, 1'b0, 6);
    wait_sc;
    chk({track0, write_fault}, 2'h2);
    smd_ctrl_model_inst.seek(1, 1'b0, 6);
    wait_sc;
    chk(track0, 1'b1);
  endtask
  // burst faster than travel, counted back one step at a time
  task automatic t_buffer;
    int k;
    smd_ctrl_model_inst.seek(4, 1'b1, 6);
    wait_sc;
    k = 0;
    while (track0 !== 1'b1 && k < 10) begin
      smd_ctrl_model_inst.seek(1, 1'b0, 6);
      wait_sc;
      k++;
    end
    chk(k, 4);
  endtask
  // only address 1 answers, address zero ignores steps
  task automatic t_select;
    for (int u = 0; u < 4; u++) begin
      @(negedge clk);
      unit_sel = u[1:0];
      repeat (4) @(negedge clk);
      chk(drive_selected, u == 1);
    end
    unit_sel = 2'h0;
    repeat (4) @(negedge clk);
    smd_ctrl_model_inst.seek(1, 1'b1, 30);
    chk({seek_complete, track0}, 2'h3);
    unit_sel = 2'h1;
    repeat (4) @(negedge clk);
  endtask
  // one write case, then everything back to quiet
  task automatic wf(input logic g, input logic r, input logic [3:0] h,
                    input logic s, input logic c, input logic e);
    @(negedge clk);
    {write_gate, read_gate, head_sel, spin_ok, write_current} =
      {g, r, h, s, c};
    repeat (10) @(negedge clk);
    chk(write_fault, e);
    chk(write_enable, g & ~e);
    {write_gate, read_gate, head_sel, spin_ok, write_current} = 8'h02;
    repeat (10) @(negedge clk);
    chk(write_fault, 1'b0);
  endtask
  task automatic t_wfault;
    wf(1'b1, 1'b0, 4'h0, 1'b1, 1'b1, 1'b0);
    wf(1'b1, 1'b1, 4'h0, 1'b1, 1'b1, 1'b1);
    wf(1'b1, 1'b0, 4'h9, 1'b1, 1'b1, 1'b1);
    wf(1'b1, 1'b0, 4'hf, 1'b1, 1'b1, 1'b1);
    wf(1'b1, 1'b0, 4'h0, 1'b0, 1'b1, 1'b1);
    wf(1'b1, 1'b0, 4'h0, 1'b1, 1'b0, 1'b1);
    wf(1'b0, 1'b0, 4'h0, 1'b1, 1'b1, 1'b1);
  endtask
  // minimum length preamble from the controller reaches the head as is
  task automatic t_sync;
    int i;
    logic [2:0] hist;
    hist = 3'h0;
    @(negedge clk);
    {write_gate, read_gate, head_sel, spin_ok, write_current} = 8'h83;
    for (i = 0; i < SYNC_MIN_BYTES * BITS_PER_BYTE * REF_DIV; i++) begin
      @(negedge clk);
      hist = {hist[1:0], write_data};
      // two sync stages plus the output flop
      if (i > 8)
        chk(write_bit, hist[2]);
    end
    chk(write_fault, 1'b0);
    {write_gate, read_gate, head_sel, spin_ok, write_current} = 8'h02;
    repeat (10) @(negedge clk);
  endtask
  // index width and spacing, reference clock period, gap around index
  task automatic t_index;
    int n;
    n = 0;
    while (index_pulse !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk(gap_window, 1'b1);
    n = 0;
    while (index_pulse === 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk(n, INDEX_HI_REFS * REF_DIV);
    // closed 12 bytes past index, open again 4 bytes before the next
    repeat (2000) @(negedge clk);
    chk(gap_window, 1'b0);
    repeat (2500) @(negedge clk);
    chk(gap_window, 1'b1);
    n = n + 4500;
    while (index_pulse !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk(n, 5000);
    @(posedge ref_clk);
    n = 0;
    @(negedge clk);
    while (ref_clk === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    while (ref_clk !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n, REF_DIV);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    mismatches = 0;
    n_compared = 0;
    rst = 1'b1;
    unit_sel = 2'h1;
    {write_gate, read_gate, head_sel, spin_ok, write_current} = 8'h02;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    t_reset;
    t_drop;
    t_over;
    t_buffer;
    t_select;
    t_wfault;
    t_sync;
    t_index;
    stop_test;
  end
endmodule

// *** src/smd_drive.sv ***
// Purpose: step-mode head positioning and write safety of a disk drive
// Assumes: controller keeps its side of the step protocol
// Notes:   head motion is modelled as a timed track counter
`timescale 1ns/10ps
module smd_drive
  import smd_pkg::*;
#(
  parameter int UNIT_ADDR  = 1,        // strap, 1..3
  parameter int SETTLE_LEN = SETTLE_CYC,
  parameter int REV_LEN    = REV_CYC,
  parameter int MOVE_LEN   = TRACK_MOVE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] unit_sel,      // drive select lines
  input  wire logic [3:0] head_sel,      // binary weighted heads
  input  wire logic       write_gate,
  input  wire logic       read_gate,
  input  wire logic       direction_in,
  input  wire logic       step,
  input  wire logic       write_data,    // nrz write data
  input  wire logic       write_current, // sense of head current
  input  wire logic       spin_ok,       // spindle at speed
  output logic            drive_selected,
  output logic            ready,
  output logic            seek_complete,
  output logic            track0,
  output logic            write_fault,
  output logic            index_pulse,
  output logic            ref_clk,       // 5 MHz reference clock
  output logic            write_enable,  // head write allowed
  output logic            write_bit,     // data to the head
  output logic            gap_window,    // intersector gap active
  output logic            prot_oe_n,     // write protect oe, never low
  output logic            prot_o,
  output logic            chg_oe_n,      // cartridge changed oe
  output logic            chg_o
);
  // ==========================================================
  // pin synchronisers
  localparam int NS = 13;
  logic [NS-1:0] pin_raw, pin_s;
  assign pin_raw = {unit_sel, head_sel, write_gate, read_gate,
                    direction_in, step, write_data, write_current,
                    spin_ok};
  smd_sync #(.W(NS)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pin_raw),
    .q   (pin_s)
  );
  smd_ctl_t   ctl;             // synchronised control group
  logic [1:0] unit_s;
  logic       step_s, wdata_s, wcur_s, spin_s;
  assign unit_s = pin_s[12:11];
  assign ctl    = smd_ctl_t'({pin_s[6], pin_s[5], pin_s[4],
                              pin_s[10:7]});
  assign step_s = pin_s[3];
  assign wdata_s = pin_s[2];
  assign wcur_s  = pin_s[1];
  assign spin_s  = pin_s[0];

  // ==========================================================
  // select decode
  logic sel;
  // address zero never answers; only three units exist
  assign sel = (unit_s != UNIT_INVALID) &&
               (unit_s == 2'(UNIT_ADDR));
  assign drive_selected = sel;
  // serial command and status lines are simply absent here
  assign prot_oe_n = 1'b1;
  assign prot_o    = 1'b0;
  assign chg_oe_n  = 1'b1;
  assign chg_o     = 1'b0;

  // ==========================================================
  // step edge detect and buffering
  logic        step_d_r;          // previous synchronised step
  logic        step_rise;
  logic [10:0] pend_r, pend_nxt;  // buffered signed step count
  logic [10:0] trk_r, trk_nxt;    // current track
  smd_seek_t   st_r, st_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  assign step_rise = step_s && !step_d_r && sel;
  always_ff @(posedge clk) begin
    if (rst) step_d_r <= 1'b0;
    else     step_d_r <= step_s;
  end

  // direction sampled at each pulse; in adds, out subtracts
  logic [10:0] pend_add;
  assign pend_add = step_rise ? (ctl.direction_in ? 11'h001 : 11'h7ff)
                              : 11'h000;
  logic move_done;
  logic        mv_in;
  assign mv_in = !pend_r[10];
  assign move_done = (st_r == SMD_MOVE) && (tmr_r == 32'h0) &&
                     (pend_r != 11'h000);

  // ==========================================================
  // seek sequencer, any spacing accepted since each pulse is queued
  always_comb begin
    st_nxt   = st_r;
    tmr_nxt  = (tmr_r != 32'h0) ? tmr_r - 32'h1 : 32'h0;
    trk_nxt  = trk_r;
    pend_nxt = pend_r + pend_add;
    case (st_r)
      SMD_IDLE: begin
        if (step_rise) begin
          st_nxt  = SMD_MOVE;
          tmr_nxt = 32'(MOVE_LEN);
        end
      end
      SMD_MOVE: begin
        if (move_done) begin
          // clamp at the boundary tracks, excess steps dropped
          if (mv_in && trk_r < 11'(MAX_TRACK))
            trk_nxt = trk_r + 11'h001;
          else if (!mv_in && trk_r != 11'h000)
            trk_nxt = trk_r - 11'h001;
          pend_nxt = pend_r + pend_add + (mv_in ? 11'h7ff : 11'h001);
          tmr_nxt  = 32'(MOVE_LEN);
        end else if (pend_r == 11'h000 && tmr_r == 32'h0 &&
                     !step_rise) begin
          // a pulse landing on this very cycle keeps the seek open
          st_nxt  = SMD_SETTLE;
          tmr_nxt = 32'(SETTLE_LEN);
        end
      end
      SMD_SETTLE: begin
        // a late pulse up to 3 ms away still belongs to this seek
        if (step_rise) begin
          st_nxt  = SMD_MOVE;
          tmr_nxt = 32'(MOVE_LEN);
        end else if (tmr_r == 32'h0) begin
          st_nxt = SMD_IDLE;
        end
      end
      default: st_nxt = SMD_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= SMD_IDLE;
      tmr_r  <= 32'h0;
      trk_r  <= 11'h000;
      pend_r <= 11'h000;
    end else begin
      st_r   <= st_nxt;
      tmr_r  <= tmr_nxt;
      trk_r  <= trk_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ==========================================================
  // status outputs; seek complete falls on the next clock after
  // the synchronised edge, well within the allowed window
  logic sc_r, t0_r, rdy_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      sc_r  <= 1'b1;
      t0_r  <= 1'b1;
      rdy_r <= 1'b0;
    end else begin
      sc_r  <= (st_nxt == SMD_IDLE) && !step_rise;
      t0_r  <= (trk_nxt == 11'h000);
      rdy_r <= spin_s;
    end
  end
  assign seek_complete = sc_r;
  assign track0        = t0_r;
  assign ready         = rdy_r;

  // ==========================================================
  // write fault: sticky until write gate drops and current is gone
  logic head_bad, on_cyl, wf_set, wf_r;
  assign head_bad = (ctl.head_sel >= 4'(NUM_HEADS));
  assign on_cyl   = (st_r == SMD_IDLE);
  // write data activity: nrz data may sit low for a while, so its
  // level says nothing; a stream with no edge for a byte is missing
  localparam int WD_IDLE_CYC = BITS_PER_BYTE * REF_DIV;
  logic       wdata_d_r;          // previous synchronised write data
  logic [7:0] wd_idle_r;          // cycles since last data edge
  logic       no_wdata;           // no data edge for a whole byte
  always_ff @(posedge clk) begin
    if (rst) begin
      wdata_d_r <= 1'b0;
      wd_idle_r <= 8'h00;
    end else begin
      wdata_d_r <= wdata_s;
      // cleared while the gate is down, so a fresh gate starts clean
      if (!ctl.write_gate || (wdata_s != wdata_d_r))
        wd_idle_r <= 8'h00;
      else if (!no_wdata)
        wd_idle_r <= wd_idle_r + 8'h01;
    end
  end
  assign no_wdata = (wd_idle_r == 8'(WD_IDLE_CYC));
  assign wf_set = (ctl.write_gate && (!wcur_s || no_wdata ||
                    !rdy_r || !sc_r || head_bad || !on_cyl ||
                    ctl.read_gate))
                || (!ctl.write_gate && wcur_s);
  always_ff @(posedge clk) begin
    if (rst) wf_r <= 1'b0;
    else     wf_r <= wf_set || (wf_r && ctl.write_gate);
  end
  assign write_fault = wf_r;
  // writing blocked by fault as well as by not ready
  assign write_enable = sel && ctl.write_gate && rdy_r && !wf_r;
  // controller's sync pattern goes straight through, none added
  logic wbit_r;
  always_ff @(posedge clk) begin
    if (rst) wbit_r <= 1'b0;
    else     wbit_r <= write_enable ? wdata_s : 1'b0;
  end
  assign write_bit = wbit_r;

  // ==========================================================
  // reference clock, index and gap window
  logic [7:0]  div_r;
  logic        rclk_r;
  logic [31:0] rev_r;
  logic [31:0] bitc_r;
  localparam int HALF_DIV  = REF_DIV / 2;
  localparam int IDX_CYC   = INDEX_HI_REFS * REF_DIV;
  localparam int GAP_CYC   = GAP_BYTES * BITS_PER_BYTE * REF_DIV;
  localparam int LEAD_CYC  = GAP_LEAD_BYTES * BITS_PER_BYTE * REF_DIV;
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r  <= 8'h00;
      rclk_r <= 1'b0;
    end else if (div_r == 8'(HALF_DIV - 1)) begin
      div_r  <= 8'h00;
      rclk_r <= !rclk_r;
    end else begin
      div_r  <= div_r + 8'h01;
    end
  end
  assign ref_clk = rclk_r;
  always_ff @(posedge clk) begin
    if (rst) rev_r <= 32'h0;
    else if (rev_r == 32'(REV_LEN - 1)) rev_r <= 32'h0;
    else rev_r <= rev_r + 32'h1;
  end
  assign bitc_r = rev_r;
  logic idx_r, gap_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_r <= 1'b0;
      gap_r <= 1'b0;
    end else begin
      idx_r <= (rev_r < 32'(IDX_CYC));
      gap_r <= (bitc_r >= 32'(REV_LEN - LEAD_CYC)) ||
               (bitc_r < 32'(GAP_CYC - LEAD_CYC));
    end
  end
  assign index_pulse = idx_r;
  assign gap_window  = gap_r;

  // ==========================================================
  // checks
  property p_sc_drop;
    @(posedge clk) disable iff (rst)
      step_rise |=> !seek_complete;
  endproperty
  a_sc_drop: assert property (p_sc_drop)
    else $error("seek complete not dropped after step");
  property p_trk_max;
    @(posedge clk) disable iff (rst)
      trk_r <= 11'(MAX_TRACK);
  endproperty
  a_trk_max: assert property (p_trk_max)
    else $error("track beyond maximum");
  property p_wf_gate;
    @(posedge clk) disable iff (rst)
      (!ctl.write_gate && wcur_s) |=> write_fault;
  endproperty
  a_wf_gate: assert property (p_wf_gate)
    else $error("no fault on stray write current");
  property p_wf_rg;
    @(posedge clk) disable iff (rst)
      (ctl.write_gate && ctl.read_gate) |=> write_fault;
  endproperty
  a_wf_rg: assert property (p_wf_rg)
    else $error("no fault with read gate during write");
  property p_block;
    @(posedge clk) disable iff (rst)
      write_fault |-> !write_enable ##1 !write_bit;
  endproperty
  a_block: assert property (p_block)
    else $error("write allowed during fault");
  property p_sel0;
    @(posedge clk) disable iff (rst)
      (unit_s == UNIT_INVALID) |-> !drive_selected;
  endproperty
  a_sel0: assert property (p_sel0)
    else $error("unit zero selected");
  property p_idx;
    @(posedge clk) disable iff (rst)
      $rose(index_pulse) |-> index_pulse [*8];
  endproperty
  a_idx: assert property (p_idx)
    else $error("index pulse too short");
  property p_open;
    @(posedge clk) prot_oe_n && chg_oe_n;
  endproperty
  a_open: assert property (p_open)
    else $error("unimplemented line driven");
  property p_t0;
    @(posedge clk) disable iff (rst)
      (move_done && !mv_in && trk_r == 11'h001) |=> track0;
  endproperty
  a_t0: assert property (p_t0)
    else $error("track zero flag missing");
endmodule

// *** src/smd_pkg.sv ***
// Purpose: constants and carriers for the step-mode drive interface logic
// Assumes: core clock 100 MHz, reference clock 5 MHz derived internally
// Notes:   timing counts are derived from times printed in their own unit
// How it works
// - accept step pulses spaced 4 us to 200 us
// - also accept steps spaced 3 ms apart
// - buffer steps, move on first, allow overrun
// - drop seek complete within 500 ns of step
// - clamp heads to track zero or max track
// - many reverse steps leave heads on zero
// - write gate never makes own sync preamble
// - three units only, unit address zero invalid
// - write gate faults on any unsafe condition
// - write current without write gate is fault
// - write fault blocks all writing
// - protect and changed lines left undriven
// - data clock 5 MHz, 200 ns period
// - 16 byte gap, starts four bytes early
// - four binary weighted head select lines
// - no serial-mode command or status signals
// - index once per rev, eight clocks high
package smd_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ          = 100;
  localparam int REF_PERIOD_NS    = 200;  // read/write clock period
  localparam int REF_DIV          = REF_PERIOD_NS * CLK_MHZ / 1000;
  localparam int SC_DROP_NS       = 500;  // longest seek-complete drop
  localparam int SC_DROP_CYC      = SC_DROP_NS * CLK_MHZ / 1000;
  localparam int STEP_MIN_NS      = 4000; // shortest accepted spacing
  localparam int STEP_MIN_CYC     = (STEP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_US        = 3000; // 3 ms wait for a late pulse
  localparam int SETTLE_CYC       = SETTLE_US * CLK_MHZ;
  localparam int TRACK_MOVE_NS    = 2000; // head travel per track
  localparam int TRACK_MOVE_CYC   = TRACK_MOVE_NS * CLK_MHZ / 1000;
  localparam int INDEX_HI_REFS    = 8;
  localparam int REV_US           = 16670;
  localparam int REV_CYC          = REV_US * CLK_MHZ;
  // ==========================================================
  // geometry and format
  localparam int MAX_TRACK        = 924;
  localparam int NUM_HEADS        = 9;
  localparam int GAP_BYTES        = 16;
  localparam int GAP_LEAD_BYTES   = 4;
  localparam int SYNC_MIN_BYTES   = 11;
  localparam int BITS_PER_BYTE    = 8;
  localparam logic [1:0] UNIT_INVALID = 2'h0;
  // ==========================================================
  // seek state machine
  typedef enum logic [1:0] {
    SMD_IDLE   = 2'b00,
    SMD_MOVE   = 2'b01,
    SMD_SETTLE = 2'b10
  } smd_seek_t;
  // controller-side control lines
  typedef struct packed {
    logic       write_gate;
    logic       read_gate;
    logic       direction_in;
    logic [3:0] head_sel;
  } smd_ctl_t;
  // drive status lines
  typedef struct packed {
    logic ready;
    logic seek_complete;
    logic track0;
    logic write_fault;
    logic index;
    logic selected;
  } smd_stat_t;
endpackage

// *** src/smd_sync.sv ***
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module smd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;  // first stage, metastable window
  // ==========================================================
  // two stage capture
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
